// ---- design/common_command_status_unit.sv ----
// Common command interpreter with status byte and event registers on a Wishbone slave
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Questionable summary is OR of questionable events ANDed with their enable mask.
// - Power-up clears questionable enable mask or keeps it, per power-on clear flag.
// - Questionable enable mask survives instrument clear and the clear-status command.
// - Identification answers maker, model, serial and revision fields, last two ASCII decimal.
// - Queries after identification in one message raise query error and give no reply.
// - Reset returns settings to defaults but leaves remote interface settings alone.
// - Reset during trigger wait or measuring sends the instrument into hold.
// - Self-test during trigger wait or measuring raises execution error, no reply.
// - Self-test replies 0 when firmware check passes, -1 when it fails.
// - Done command sets operation complete bit once earlier operations finish.
// - Done query queues ASCII 1 after earlier operations, event register untouched.
// - Wait command holds later commands until earlier operations finish.
// - Clear-status empties event registers and the summary bits fed by them.
// - Event register query returns its contents and clears it in the same read.
// - Power-on clear flag chooses automatic clearing of enable registers; query reports it.
// - Enable commands load event and service request masks; queries return them ANDed with 8'hBD and 8'hB9.
// - Status query returns status byte including master summary bit.
// - Save stores current settings to a setup slot; recall restores from one.
// - Event register bits: 7 power-on, 5 command, 4 execution, 3 instrument, 2 query, 0 complete.
// - Flag zero keeps enable registers over power-off; nonzero clears them at power-on.
module common_command_status_unit
   import ccsu_pkg::*;
#(
   parameter int          RQ_DEPTH      = 4,
   parameter logic [31:0] MAKER_CODE    = 32'h0000_0A5A, // Arbitrary value
   parameter logic [31:0] MODEL_CODE    = 32'h0000_0B6B, // Arbitrary value
   parameter logic [31:0] SERIAL_NUMBER = 32'h3030_3031,
   parameter logic [31:0] FW_REVISION   = 32'h3031_3030
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [7:0]  ADR_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic [3:0]  SEL_I,
   output var  logic        ACK_O,
   output var  logic [31:0] DAT_O,
   input  wire logic        OP_BUSY,
   input  wire logic        WAIT_TRIG,
   input  wire logic        MEASURING,
   input  wire logic        FW_OK,
   input  wire logic        PSC_STORED,
   input  wire logic        INSTR_ERROR,
   input  wire logic [15:0] QUEST_EVENT,
   input  wire logic        OPER_SUMMARY,
   input  wire logic        MEAS_SUMMARY,
   output var  logic [7:0]  STATUS_BYTE,
   output var  logic        SERVICE_REQ,
   output var  logic        PSC_FLAG,
   output var  logic        SETTINGS_RESET,
   output var  logic        HOLD_REQ,
   output var  logic        TRIGGER,
   output var  logic        SAVE_SETUP,
   output var  logic        RECALL_SETUP,
   output var  logic [7:0]  SETUP_SLOT,
   output var  logic        CLEAR_EVENTS
);
   localparam int PW = (RQ_DEPTH > 1) ? $clog2(RQ_DEPTH) : 1;
   localparam int CW = $clog2(RQ_DEPTH + 1);

   function automatic logic is_query(input logic [4:0] c);
      return c == CMD_IDENT_Q || c == CMD_TEST_Q || c == CMD_DONE_Q || c == CMD_EV_EN_Q
          || c == CMD_EV_REG_Q || c == CMD_PWR_CLR_Q || c == CMD_SRQ_EN_Q || c == CMD_STATUS_Q
          || c == CMD_QUEST_EV_Q;
   endfunction

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      return (p == PW'(RQ_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   state_type     state;
   state_type     next_state;
   logic [1:0]    idn_idx;
   logic          ack;
   logic          idn_lock;
   logic          op_pend;
   logic          psc;
   logic [7:0]    esr;
   logic [7:0]    ese;
   logic [7:0]    sre;
   logic [15:0]   qev;
   logic [15:0]   qena;
   logic [31:0]   resp_mem [RQ_DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic [31:0]   reply;
   logic [31:0]   ident_word;
   logic [31:0]   read_word;
   cmd_type       cmd;

   // Bus request decode; only a command write can be held off
   wire req      = CYC_I & STB_I & ~ack;
   wire full     = count == CW'(RQ_DEPTH);
   wire empty    = count == '0;
   wire stall    = (state != ST_IDLE) | full;
   wire wr_cmd   = req & WE_I & (ADR_I == ADR_CMD) & (&SEL_I[2:0]);
   wire wr_quest = req & WE_I & (ADR_I == ADR_QUEST);
   wire rd_resp  = req & ~WE_I & (ADR_I == ADR_RESP);
   wire go       = req & ~(wr_cmd & stall);
   wire take     = wr_cmd & ~stall;
   assign cmd = '{last: DAT_I[CMD_LAST_POS], arg: DAT_I[CMD_ARG_LSB +: 8], code: DAT_I[CMD_CODE_LSB +: 5]};

   // Queries behind an identification query in the same message are dropped
   wire query     = is_query(cmd.code);
   wire blocked   = take & idn_lock & query;
   wire run       = take & ~blocked;
   wire busy_meas = WAIT_TRIG | MEASURING;
   wire unknown   = take & (cmd.code > CMD_LAST_CODE);

   // One strobe per command, except the enable, flag and status queries
   wire do_idn   = run & (cmd.code == CMD_IDENT_Q);
   wire do_rst   = run & (cmd.code == CMD_RESET);
   wire do_tst   = run & (cmd.code == CMD_TEST_Q);
   wire do_done  = run & (cmd.code == CMD_DONE);
   wire do_doneq = run & (cmd.code == CMD_DONE_Q);
   wire do_wai   = run & (cmd.code == CMD_WAIT);
   wire do_cls   = run & (cmd.code == CMD_CLEAR);
   wire do_ese   = run & (cmd.code == CMD_EV_EN);
   wire do_esrq  = run & (cmd.code == CMD_EV_REG_Q);
   wire do_psc   = run & (cmd.code == CMD_PWR_CLR);
   wire do_sre   = run & (cmd.code == CMD_SRQ_EN);
   wire do_trg   = run & (cmd.code == CMD_TRIGGER);
   wire do_rcl   = run & (cmd.code == CMD_RECALL);
   wire do_sav   = run & (cmd.code == CMD_SAVE);
   wire do_qevq  = run & (cmd.code == CMD_QUEST_EV_Q);

   // Summaries are pure combinational terms so they track every change at once
   wire esb       = |(esr & ese);
   wire qsum      = |(qev & qena);
   wire [7:0] stb_low = {OPER_SUMMARY, 1'b0, esb, ~empty, qsum, 2'b00, MEAS_SUMMARY};
   wire master_sum = |(stb_low & sre);
   wire [7:0] stb_now = {stb_low[7], master_sum, stb_low[5:0]};

   // Response queue pushes: at most one source can be active per cycle
   wire test_busy  = do_tst & busy_meas;
   wire imm_push   = run & query & ~test_busy & (cmd.code != CMD_IDENT_Q) & (cmd.code != CMD_DONE_Q);
   wire ident_push = (state == ST_IDENT) & ~full;
   wire doneq_push = (state == ST_DONEQ) & ~OP_BUSY & ~full;
   wire push       = imm_push | ident_push | doneq_push;
   wire pop        = rd_resp & ~empty;
   wire [31:0] push_data = ident_push ? ident_word : doneq_push ? DONE_REPLY : reply;
   wire op_fire    = op_pend & ~OP_BUSY;

   // Event register set and clear; a set in the clearing cycle survives
   wire [7:0] esr_set = {1'b0, 1'b0, unknown, test_busy, INSTR_ERROR, blocked, 1'b0, op_fire};
   wire       esr_clr = do_cls | do_esrq;
   wire       qev_clr = do_cls | do_qevq;
   wire [7:0]  next_esr = (esr & ~{8{esr_clr}}) | esr_set;
   wire [15:0] next_qev = (qev & ~{16{qev_clr}}) | QUEST_EVENT;

   // Identification fields in reply order
   always_comb begin
      case (idn_idx)
         2'h0:    ident_word = MAKER_CODE;
         2'h1:    ident_word = MODEL_CODE;
         2'h2:    ident_word = SERIAL_NUMBER;
         default: ident_word = FW_REVISION;
      endcase
   end

   // Immediate query replies
   always_comb begin
      case (cmd.code)
         CMD_TEST_Q:     reply = FW_OK ? TEST_PASS : TEST_FAIL;
         CMD_EV_EN_Q:    reply = {24'h000000, ese & EVENT_ENABLE_READ_MASK};
         CMD_EV_REG_Q:   reply = {24'h000000, esr};
         CMD_PWR_CLR_Q:  reply = {31'h00000000, psc};
         CMD_SRQ_EN_Q:   reply = {24'h000000, sre & SRQ_ENABLE_READ_MASK};
         CMD_STATUS_Q:   reply = {24'h000000, stb_now};
         CMD_QUEST_EV_Q: reply = {16'h0000, qev};
         default:        reply = 32'h00000000;
      endcase
   end

   // Bus read data
   always_comb begin
      case (ADR_I)
         ADR_CMD:   read_word = {28'h0000000, idn_lock, op_pend, state};
         ADR_RESP:  read_word = empty ? 32'h00000000 : resp_mem[rd_ptr];
         ADR_STAT:  read_word = {8'h00, 8'(count), esr, stb_now};
         ADR_QUEST: read_word = {qena, qev};
         default:   read_word = 32'h00000000;
      endcase
   end

   // Sequencer: wait hold, delayed done reply, identification burst
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (do_wai)
               next_state = ST_WAIT;
            else if (do_doneq)
               next_state = ST_DONEQ;
            else if (do_idn)
               next_state = ST_IDENT;
         end
         ST_WAIT: begin
            if (!OP_BUSY)
               next_state = ST_IDLE;
         end
         ST_DONEQ: begin
            if (doneq_push)
               next_state = ST_IDLE;
         end
         ST_IDENT: begin
            if (ident_push && idn_idx == LAST_IDENT_FIELD)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Bus handshake; ack drops the cycle after it rises
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         ack   <= 1'b0;
         DAT_O <= 32'h00000000;
      end else begin
         ack   <= go;
         DAT_O <= go ? read_word : 32'h00000000;
      end
   end
   assign ACK_O = ack;

   // Sequencer and message tracking
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state    <= ST_IDLE;
         idn_idx  <= 2'h0;
         idn_lock <= 1'b0;
         op_pend  <= 1'b0;
      end else begin
         state    <= next_state;
         idn_idx  <= do_idn ? 2'h0 : ident_push ? idn_idx + 2'h1 : idn_idx;
         idn_lock <= take ? (do_idn & ~cmd.last) | (idn_lock & ~cmd.last) : idn_lock;
         op_pend  <= (do_done | (op_pend & ~op_fire)) & ~do_rst;
      end
   end

   // Event registers; reset marks power-on
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         esr <= EVENT_RESET;
         qev <= 16'h0000;
      end else begin
         esr <= next_esr;
         qev <= next_qev;
      end
   end

   // Enable masks: kept over power cycles unless the stored flag asks for clearing.
   // Clear-status and instrument reset never touch them.
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         psc <= PSC_STORED;
         if (PSC_STORED) begin
            ese  <= 8'h00;
            sre  <= 8'h00;
            qena <= 16'h0000;
         end
      end else begin
         if (do_psc)
            psc <= cmd.arg != 8'h00;
         if (do_ese)
            ese <= cmd.arg;
         if (do_sre)
            sre <= cmd.arg;
         if (wr_quest && SEL_I[2])
            qena[7:0] <= DAT_I[23:16];
         if (wr_quest && SEL_I[3])
            qena[15:8] <= DAT_I[31:24];
      end
   end

   // Response queue pointers
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push)
            wr_ptr <= bump(wr_ptr);
         if (pop)
            rd_ptr <= bump(rd_ptr);
         count <= CW'(count + CW'(push) - CW'(pop));
      end
   end

   // Response storage
   always_ff @(posedge CLOCK) begin
      if (push)
         resp_mem[wr_ptr] <= push_data;
   end

   // Instrument-facing pulses and registered status
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         SETTINGS_RESET <= 1'b0;
         HOLD_REQ       <= 1'b0;
         TRIGGER        <= 1'b0;
         SAVE_SETUP     <= 1'b0;
         RECALL_SETUP   <= 1'b0;
         SETUP_SLOT     <= 8'h00;
         CLEAR_EVENTS   <= 1'b0;
         STATUS_BYTE    <= 8'h00;
         SERVICE_REQ    <= 1'b0;
         PSC_FLAG       <= 1'b0;
      end else begin
         SETTINGS_RESET <= do_rst;
         HOLD_REQ       <= do_rst & busy_meas;
         TRIGGER        <= do_trg;
         SAVE_SETUP     <= do_sav;
         RECALL_SETUP   <= do_rcl;
         SETUP_SLOT     <= (do_sav | do_rcl) ? cmd.arg : SETUP_SLOT;
         CLEAR_EVENTS   <= do_cls;
         STATUS_BYTE    <= stb_now;
         SERVICE_REQ    <= master_sum;
         PSC_FLAG       <= psc;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   a_quest_summary: assert property (STATUS_BYTE[3] == $past(|(qev & qena)))
      else $error("questionable summary wrong");
   // Watches the reset cycle itself, so the default reset gating must not apply
   a_power_clear: assert property (disable iff (1'b0) RESET && PSC_STORED |=> qena == 16'h0000 && ese == 8'h00 && sre == 8'h00)
      else $error("enables not cleared at power-up");
   a_mask_survives: assert property (do_cls && !wr_quest |=> $stable(qena))
      else $error("questionable mask changed by clear");
   a_ident_first: assert property (do_idn ##1 ident_push |-> push_data == MAKER_CODE)
      else $error("identification field order wrong");
   a_query_block: assert property (blocked |=> esr[QUERY_ERROR_BIT] && count == $past(count))
      else $error("blocked query not handled");
   a_reset_hold: assert property (do_rst && busy_meas |=> HOLD_REQ && SETTINGS_RESET)
      else $error("reset did not request hold");
   a_test_busy: assert property (test_busy |=> esr[EXECUTION_ERROR_BIT] && count == $past(count))
      else $error("busy self-test not refused");
   a_test_value: assert property (do_tst && !busy_meas |-> push && push_data == (FW_OK ? TEST_PASS : TEST_FAIL))
      else $error("self-test reply wrong");
   a_done_bit: assert property (op_pend && !OP_BUSY |=> esr[OPERATION_COMPLETE_BIT])
      else $error("operation complete not set");
   a_done_reply: assert property (doneq_push && !op_pend |-> push_data == DONE_REPLY && !esr_set[OPERATION_COMPLETE_BIT])
      else $error("done query reply wrong");
   a_wait_hold: assert property (state == ST_WAIT && OP_BUSY |-> !take)
      else $error("command taken during wait");
   a_clear_status: assert property (do_cls && !INSTR_ERROR && !op_pend |=> esr == 8'h00)
      else $error("clear status left events");
   a_event_read: assert property (do_esrq |-> push_data == {24'h000000, esr} ##1 !esr[COMMAND_ERROR_BIT])
      else $error("event read not cleared");
   a_flag_report: assert property (do_psc |=> ##1 PSC_FLAG == ($past(cmd.arg, 2) != 8'h00))
      else $error("power-on clear flag wrong");
   a_mask_reply: assert property (do_ese |=> ese == $past(cmd.arg))
      else $error("event enable not loaded");
   a_master_sum: assert property (STATUS_BYTE[6] == |(STATUS_BYTE & $past(sre) & 8'hBF))
      else $error("master summary wrong");
   a_save_slot: assert property (do_sav |=> SAVE_SETUP && SETUP_SLOT == $past(cmd.arg))
      else $error("save slot wrong");
   a_unused_bits: assert property (!esr[6] && !esr[1])
      else $error("unused event bit set");

   c_ident_read: cover property (do_idn ##[1:8] pop);
   c_wait_done:  cover property (state == ST_WAIT ##1 state == ST_IDLE);
   c_blocked:    cover property (blocked);
   c_done_bit:   cover property (op_pend ##1 esr[OPERATION_COMPLETE_BIT]);
endmodule // common_command_status_unit

`default_nettype wire

// ---- pkg/ccsu_pkg.sv ----
// Shared constants, command codes and types of the common command and status unit
package ccsu_pkg;
   // Register byte offsets
   localparam logic [7:0] ADR_CMD   = 8'h00;
   localparam logic [7:0] ADR_RESP  = 8'h04;
   localparam logic [7:0] ADR_STAT  = 8'h08;
   localparam logic [7:0] ADR_QUEST = 8'h0C;
   // Command word fields
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_ARG_LSB  = 8;
   localparam int CMD_LAST_POS = 16;
   // Standard event status register bit positions
   localparam int POWER_ON_EVENT_BIT     = 7;
   localparam int COMMAND_ERROR_BIT      = 5;
   localparam int EXECUTION_ERROR_BIT    = 4;
   localparam int INSTRUMENT_ERROR_BIT   = 3;
   localparam int QUERY_ERROR_BIT        = 2;
   localparam int OPERATION_COMPLETE_BIT = 0;
   // Status byte bit positions
   localparam int OPER_SUMMARY_BIT          = 7;
   localparam int MASTER_SUMMARY_BIT        = 6;
   localparam int EVENT_SUMMARY_BIT         = 5;
   localparam int MESSAGE_AVAILABLE_BIT     = 4;
   localparam int QUESTIONABLE_SUMMARY_BIT  = 3;
   localparam int MEAS_SUMMARY_BIT          = 0;
   // Reply masks and reset values
   localparam logic [7:0]  EVENT_ENABLE_READ_MASK = 8'hBD;
   localparam logic [7:0]  SRQ_ENABLE_READ_MASK   = 8'hB9;
   localparam logic [7:0]  EVENT_RESET            = 8'h80;
   localparam logic [31:0] TEST_PASS              = 32'h0000_0000;
   localparam logic [31:0] TEST_FAIL              = 32'hFFFF_FFFF;
   localparam logic [31:0] DONE_REPLY             = 32'h0000_0031;
   localparam logic [1:0]  LAST_IDENT_FIELD       = 2'h3;
   // Command codes
   localparam logic [4:0] CMD_IDENT_Q    = 5'h00;
   localparam logic [4:0] CMD_RESET      = 5'h01;
   localparam logic [4:0] CMD_TEST_Q     = 5'h02;
   localparam logic [4:0] CMD_DONE       = 5'h03;
   localparam logic [4:0] CMD_DONE_Q     = 5'h04;
   localparam logic [4:0] CMD_WAIT       = 5'h05;
   localparam logic [4:0] CMD_CLEAR      = 5'h06;
   localparam logic [4:0] CMD_EV_EN      = 5'h07;
   localparam logic [4:0] CMD_EV_EN_Q    = 5'h08;
   localparam logic [4:0] CMD_EV_REG_Q   = 5'h09;
   localparam logic [4:0] CMD_PWR_CLR    = 5'h0A;
   localparam logic [4:0] CMD_PWR_CLR_Q  = 5'h0B;
   localparam logic [4:0] CMD_SRQ_EN     = 5'h0C;
   localparam logic [4:0] CMD_SRQ_EN_Q   = 5'h0D;
   localparam logic [4:0] CMD_STATUS_Q   = 5'h0E;
   localparam logic [4:0] CMD_TRIGGER    = 5'h0F;
   localparam logic [4:0] CMD_RECALL     = 5'h10;
   localparam logic [4:0] CMD_SAVE       = 5'h11;
   localparam logic [4:0] CMD_QUEST_EV_Q = 5'h12;
   localparam logic [4:0] CMD_LAST_CODE  = 5'h12;
   // Sequencer states, Gray coded along idle-wait-reply-ident
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DONEQ = 2'b11,
      ST_IDENT = 2'b10
   } state_type;
   // One decoded command word
   typedef struct packed {
      logic       last;
      logic [7:0] arg;
      logic [4:0] code;
   } cmd_type;
endpackage

// ---- tb/remote_ctl.sv ----
// Remote controller model: a classic Wishbone master issuing command and register cycles
`timescale 1ns/1ps
`default_nettype none
module remote_ctl (
   input  wire logic        clock,
   input  wire logic        ack,
   input  wire logic [31:0] rdat,
   output var  logic        cyc,
   output var  logic        stb,
   output var  logic        we,
   output var  logic [7:0]  adr,
   output var  logic [31:0] wdat,
   output var  logic [3:0]  sel
);
   // Bus idles from time zero
   initial {cyc, stb, we, adr, wdat, sel} = '0;

   // One cycle; released address and data lines show the inverse so a stale address or datum cannot pass unnoticed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clock); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      wdat <= ~d;
      @(posedge clock);
   endtask
endmodule // remote_ctl
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the common command and status unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module tb_top;
   import ccsu_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        cyc, stb, we, ack;
   logic [7:0]  adr, status_byte, setup_slot;
   logic [31:0] wdat, dat, r;
   logic [3:0]  sel;
   logic        op_busy = 1'b0, wait_trig = 1'b0, measuring = 1'b0, fw_ok = 1'b1;
   logic        psc_stored = 1'b1, instr_error = 1'b0, oper_sum = 1'b0, meas_sum = 1'b0;
   logic [15:0] quest_event = 16'h0000;
   logic        service_req, psc_flag, settings_reset, hold_req, trigger, save_setup, recall_setup, clear_events;
   logic [5:0]  seen = 6'h00;
   int          err_total = 0;
   int          compares = 0;
   // Arbitrary identity values
   localparam logic [31:0] IDS [4] = '{32'h0000_1357, 32'h0000_2468, 32'h3132_3334, 32'h3130_3235};

   always #2.5 clock = ~clock;

   // Sticky record of the one-cycle action pulses; outputs are unknown until reset lands
   always @(posedge clock) if (!reset) seen <= seen | {hold_req, settings_reset, trigger, save_setup, recall_setup, clear_events};

   remote_ctl remote_ctl_i (.clock(clock), .ack(ack), .rdat(dat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
                            .wdat(wdat), .sel(sel));

   common_command_status_unit #(.MAKER_CODE(IDS[0]), .MODEL_CODE(IDS[1]), .SERIAL_NUMBER(IDS[2]),
                                .FW_REVISION(IDS[3])) common_command_status_unit_i (
      .CLOCK(clock), .RESET(reset), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(wdat),
      .SEL_I(sel), .ACK_O(ack), .DAT_O(dat), .OP_BUSY(op_busy), .WAIT_TRIG(wait_trig),
      .MEASURING(measuring), .FW_OK(fw_ok), .PSC_STORED(psc_stored), .INSTR_ERROR(instr_error),
      .QUEST_EVENT(quest_event), .OPER_SUMMARY(oper_sum), .MEAS_SUMMARY(meas_sum),
      .STATUS_BYTE(status_byte), .SERVICE_REQ(service_req), .PSC_FLAG(psc_flag),
      .SETTINGS_RESET(settings_reset), .HOLD_REQ(hold_req), .TRIGGER(trigger), .SAVE_SETUP(save_setup),
      .RECALL_SETUP(recall_setup), .SETUP_SLOT(setup_slot), .CLEAR_EVENTS(clear_events));

   task automatic settle;
      repeat (3) @(posedge clock);
   endtask
   task automatic power;
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] x;
      remote_ctl_i.xfer(1'b1, a, d, s, x);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] x);
      remote_ctl_i.xfer(1'b0, a, 32'h0, 4'hF, x);
   endtask
   // Command word: code low, argument in the second byte, end-of-message flag above it
   task automatic cmd(input logic [4:0] c, input logic [7:0] g, input logic l);
      wr(ADR_CMD, {15'h0, l, g, 3'h0, c}, 4'hF);
   endtask
   task automatic q(input logic [4:0] c, output logic [31:0] x);
      cmd(c, 8'h00, 1'b1);
      rd(ADR_RESP, x);
   endtask

   task automatic t_power;
      rd(ADR_STAT, r);
      `CHK("power event", 8'h80, r[15:8])
      `CHK("psc flag", 1'b1, psc_flag)
   endtask
   task automatic t_masks;
      cmd(CMD_EV_EN, 8'hFF, 1'b1);
      q(CMD_EV_EN_Q, r);
      `CHK("ese", 32'hBD, r)
      cmd(CMD_SRQ_EN, 8'hFF, 1'b1);
      q(CMD_SRQ_EN_Q, r);
      `CHK("sre", 32'hB9, r)
      q(CMD_STATUS_Q, r);
      `CHK("stb", 32'h60, r)
      `CHK("srq", 1'b1, service_req)
      q(CMD_EV_REG_Q, r);
      `CHK("esr", 32'h80, r)
      q(CMD_EV_REG_Q, r);
      `CHK("esr cleared", 32'h00, r)
      settle;
      `CHK("status byte", 8'h00, status_byte)
      oper_sum <= 1'b1;
      meas_sum <= 1'b1;
      settle;
      `CHK("summaries", 8'hC1, status_byte)
      oper_sum <= 1'b0;
      meas_sum <= 1'b0;
      cmd(5'h1F, 8'h00, 1'b1);
      q(CMD_EV_REG_Q, r);
      `CHK("cmd error", 32'h20, r)
   endtask
   task automatic t_selftest;
      q(CMD_TEST_Q, r);
      `CHK("test pass", TEST_PASS, r)
      fw_ok <= 1'b0;
      q(CMD_TEST_Q, r);
      `CHK("test fail", TEST_FAIL, r)
      measuring <= 1'b1;
      cmd(CMD_TEST_Q, 8'h00, 1'b1);
      rd(ADR_STAT, r);
      `CHK("no reply", 8'h00, r[23:16])
      q(CMD_EV_REG_Q, r);
      `CHK("exec error", 32'h10, r)
      measuring <= 1'b0;
   endtask
   task automatic t_sync;
      op_busy <= 1'b1;
      cmd(CMD_DONE_Q, 8'h00, 1'b1);
      rd(ADR_STAT, r);
      `CHK("done early", 8'h00, r[23:16])
      op_busy <= 1'b0;
      settle;
      rd(ADR_RESP, r);
      `CHK("done reply", DONE_REPLY, r)
      q(CMD_EV_REG_Q, r);
      `CHK("esr kept", 32'h00, r)
      op_busy <= 1'b1;
      cmd(CMD_WAIT, 8'h00, 1'b1);
      fork
         cmd(CMD_TRIGGER, 8'h00, 1'b1);
         begin
            repeat (10) @(posedge clock);
            `CHK("held", 1'b0, seen[3])
            op_busy <= 1'b0;
         end
      join
      settle;
      `CHK("trigger", 1'b1, seen[3])
      op_busy <= 1'b1;
      cmd(CMD_DONE, 8'h00, 1'b1);
      rd(ADR_STAT, r);
      `CHK("opc early", 1'b0, r[8])
      op_busy <= 1'b0;
      settle;
      q(CMD_EV_REG_Q, r);
      `CHK("opc", 32'h01, r)
   endtask
   task automatic t_ident;
      cmd(CMD_IDENT_Q, 8'h00, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rd(ADR_RESP, r);
         `CHK("ident", IDS[i], r)
      end
      cmd(CMD_TEST_Q, 8'h00, 1'b1);
      rd(ADR_RESP, r);
      `CHK("no reply", 32'h0, r)
      q(CMD_EV_REG_Q, r);
      `CHK("query error", 32'h04, r)
   endtask
   task automatic t_actions;
      wait_trig <= 1'b1;
      cmd(CMD_RESET, 8'h00, 1'b1);
      settle;
      `CHK("hold", 2'b11, seen[5:4])
      wait_trig <= 1'b0;
      cmd(CMD_SAVE, 8'h05, 1'b1);
      settle;
      `CHK("save", 9'h105, {seen[2], setup_slot})
      cmd(CMD_RECALL, 8'h03, 1'b1);
      settle;
      `CHK("recall", 9'h103, {seen[1], setup_slot})
   endtask
   task automatic t_quest;
      wr(ADR_QUEST, 32'h00FF_0000, 4'hC);
      quest_event <= 16'h0100;
      @(posedge clock);
      quest_event <= 16'h0000;
      settle;
      `CHK("masked", 1'b0, status_byte[3])
      quest_event <= 16'h0001;
      instr_error <= 1'b1;
      @(posedge clock);
      quest_event <= 16'h0000;
      instr_error <= 1'b0;
      settle;
      `CHK("quest sum", 1'b1, status_byte[3])
      rd(ADR_STAT, r);
      `CHK("instr error", 8'h08, r[15:8])
      q(CMD_QUEST_EV_Q, r);
      `CHK("quest ev", 32'h0000_0101, r)
      `CHK("quest drop", 1'b0, status_byte[3])
      cmd(CMD_CLEAR, 8'h00, 1'b1);
      settle;
      rd(ADR_QUEST, r);
      `CHK("quest clr", 32'h00FF_0000, r)
      `CHK("stb clr", 9'h100, {seen[0], status_byte})
   endtask
   task automatic t_psc;
      cmd(CMD_PWR_CLR, 8'h02, 1'b1);
      q(CMD_PWR_CLR_Q, r);
      `CHK("psc one", 32'h1, r)
      cmd(CMD_PWR_CLR, 8'h00, 1'b1);
      q(CMD_PWR_CLR_Q, r);
      `CHK("psc zero", 32'h0, r)
      psc_stored <= 1'b0;
      power;
      rd(ADR_QUEST, r);
      `CHK("quest kept", 16'h00FF, r[31:16])
      q(CMD_EV_EN_Q, r);
      `CHK("ese kept", 32'hBD, r)
      psc_stored <= 1'b1;
      power;
      rd(ADR_QUEST, r);
      `CHK("quest lost", 16'h0000, r[31:16])
      q(CMD_EV_EN_Q, r);
      `CHK("ese lost", 32'h0, r)
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      repeat (2) @(posedge clock);
      t_power;
      t_masks;
      t_selftest;
      t_sync;
      t_ident;
      t_actions;
      t_quest;
      t_psc;
      complete_run;
   end

   // Watchdog: the scenarios need well under a tenth of this span
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      $display("[FAIL] watchdog expired");
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
